// ===== logic/rsi_defines.svh
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH
// register offsets on the plain port
`define RSI_ADDR_W 2
`define RSI_OFS_TRIM_UPPER 2'h0
`define RSI_OFS_INTEGRITY 2'h1
`define RSI_OFS_SOURCE 2'h2
// integrity_control_status field positions
`define RSI_BIT_TRIM_HI 6
`define RSI_BIT_TRIM_LO 5
`define RSI_BIT_WDG_FLAG 4
`define RSI_BIT_LOCKED 3
`define RSI_BIT_UV_FLAG 2
`define RSI_BIT_AUX_FLAG 1
`define RSI_BIT_AUX_IE 0
// reset values
`define RSI_TRIM_UPPER_RST 8'h80
`define RSI_TRIM_LOWER_RST 2'h3
// timing counts in cpu cycles, and the reset vector address
`define RSI_DELAY_SHORT 13'h0100
`define RSI_DELAY_LONG 13'h1000
`define RSI_FETCH_CYCLES 2'h2
`define RSI_ACTIVE_CYCLES 13'h0010
`define RSI_VECTOR_ADDR 16'hFFFE
`endif

// ===== logic/rsi_pkg.sv
`default_nettype none
package rsi_pkg;
    typedef enum logic [2:0] {
        RSI_IDLE = 3'b000,
        RSI_ACTIVE = 3'b001,
        RSI_DELAY = 3'b010,
        RSI_PLL_WAIT = 3'b011,
        RSI_FETCH = 3'b100
    } rsi_state_type;
    typedef enum logic [2:0] {
        RSI_CLK_EXT = 3'b000,
        RSI_CLK_RC = 3'b001,
        RSI_CLK_XTAL0 = 3'b010,
        RSI_CLK_XTAL1 = 3'b011,
        RSI_CLK_XTAL2 = 3'b100,
        RSI_CLK_XTAL3 = 3'b101,
        RSI_CLK_XTAL4 = 3'b110
    } rsi_clk_src_type;
    // static option-byte settings
    typedef struct packed {
        rsi_clk_src_type clk_src;
        logic pll_enable;
        logic lvd_enable;
    } rsi_option_type;
    // reset request sources
    typedef struct packed {
        logic ext_pin;
        logic low_voltage;
        logic watchdog;
        logic illegal_op;
    } rsi_source_type;
endpackage
`default_nettype wire

// ===== logic/rsi_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage level synchroniser with a reset value
module rsi_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic meta;
    // ==========================================================
    // stage pair
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= RESET_VALUE;
            dout <= RESET_VALUE;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // rsi_sync
`default_nettype wire

// ===== logic/rsi_counter.sv
`timescale 1ns/1ps
`default_nettype none
// down counter: load a length, done pulses on the last cycle
module rsi_counter #(
    parameter int WIDTH = 13
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [WIDTH-1:0] length,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count;
    // ==========================================================
    // count; length of n gives busy for n cycles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
        end else if (load) begin
            count <= length;
        end else if (count != '0) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    assign busy = (count != '0);
    assign done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // rsi_counter
`default_nettype wire

// ===== logic/rsi_reset_integrity.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_defines.svh"
// Overview of operation
// - reset requests come from the reset pin, undervoltage detector and watchdog underflow
// - an illegal opcode or prebyte from the cpu also starts a reset
// - the reset pin is driven low throughout the delay phase
// - the cpu fetches its start address from the top two bytes
// - each reset runs active phase, cycle delay, then vector fetch, in order
// - delay is 256 cycles for rc or external clock, 4096 for a resonator
// - the vector fetch phase lasts exactly two clock cycles
// - with the pll enabled, clock output waits an extra startup interval
// - a selected resonator keeps running during reset
// - the external reset is seen even with the clock stopped in halt
// - a watchdog underflow drives the pin low for the minimum pulse width
// - undervoltage holds a static reset and drives the pin low
// - the auxiliary detector works only when the undervoltage detector is enabled
// - the auxiliary flag mirrors the comparator live and ignores writes
// - aux interrupt needs the event, its enable and the cpu mask clear
// - in wait the logic runs on and the aux interrupt wakes the device
// - in halt the status register freezes and aux cannot wake the device
// - the aux interrupt is raised when the flag becomes set
// - rc trim is eight upper bits plus two lower bits at six to five
// - the clock source comes from static option settings
// - watchdog flag set by watchdog reset, cleared by read or undervoltage reset
// - undervoltage flag set by undervoltage reset, cleared by read only
// - the pll lock flag follows the pll reaching its frequency
module rsi_reset_integrity #(
    parameter int PLL_STARTUP_CYCLES = 32,
    parameter int WDG_PULSE_CYCLES = 16
) (
    input wire logic clk,
    input wire logic rstn,
    // options
    input wire rsi_pkg::rsi_option_type option,
    // reset pin, open drain
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // internal sources
    input wire logic low_voltage_detector,
    input wire logic auxiliary_voltage_detector,
    input wire logic watchdog_underflow,
    input wire logic illegal_opcode,
    input wire logic pll_at_frequency,
    input wire logic cpu_interrupt_mask,
    input wire logic wait_mode,
    input wire logic halt_mode,
    // register port
    input wire logic [`RSI_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // cpu side
    output logic cpu_reset,
    output logic cpu_clock_enable,
    output logic vector_fetch,
    output logic [15:0] reset_vector,
    output logic aux_voltage_irq,
    output logic wake_from_wait,
    output logic oscillator_keep_running,
    output logic [9:0] rc_trim
);
    localparam logic [12:0] PLL_LEN = 13'(PLL_STARTUP_CYCLES);
    localparam logic [12:0] WDG_LEN = 13'(WDG_PULSE_CYCLES);

    rsi_pkg::rsi_state_type state;
    rsi_pkg::rsi_state_type next_state;
    rsi_pkg::rsi_option_type opt_q;
    rsi_pkg::rsi_source_type src;
    logic pin_low_sync;
    logic uv_sync;
    logic crystal;
    logic uv_active;
    logic aux_raw;
    logic aux_flag;
    logic aux_flag_q;
    logic aux_pending;
    logic [7:0] rc_trim_upper;
    logic [1:0] rc_trim_lower;
    logic aux_voltage_irq_enable;
    logic watchdog_reset_flag;
    logic undervoltage_reset_flag;
    logic locked;
    logic [3:0] last_source;
    logic [12:0] len;
    logic load;
    logic cnt_busy;
    logic cnt_done;
    logic [1:0] fetch_cnt;
    logic start_req;
    logic integ_read;
    logic por_pending; // first cycle after rstn: the power-on sequence gets its active minimum too

    // ==========================================================
    // input conditioning
    // pin is pulled low externally; sampled through two flops so the
    // release lands on a clean edge. with the clock stopped in halt the
    // low level waits on the pin until the oscillator restarts.
    rsi_sync #(.RESET_VALUE(1'b1)) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .din(reset_pin_in),
        .dout(pin_low_sync)
    );
    rsi_sync #(.RESET_VALUE(1'b0)) u_uv_sync (
        .clk(clk),
        .rstn(rstn),
        .din(low_voltage_detector),
        .dout(uv_sync)
    );

    // source vector; pin low counts only when we are not driving it
    always_comb begin
        src.ext_pin = !pin_low_sync && !reset_pin_oe;
        src.low_voltage = uv_sync && opt_q.lvd_enable;
        src.watchdog = watchdog_underflow;
        src.illegal_op = illegal_opcode;
    end
    assign uv_active = src.low_voltage;
    assign start_req = src.ext_pin || src.low_voltage || src.watchdog || src.illegal_op;
    assign crystal = (opt_q.clk_src != rsi_pkg::RSI_CLK_EXT) && (opt_q.clk_src != rsi_pkg::RSI_CLK_RC);

    // ==========================================================
    // option sampling: only while idle, so a sequence sees fixed values
    always_ff @(posedge clk) begin
        if (!rstn) begin
            opt_q <= '0;
        end else if (state == rsi_pkg::RSI_IDLE && !start_req) begin
            opt_q <= option;
        end
    end

    // ==========================================================
    // sequencer state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= rsi_pkg::RSI_ACTIVE;
            por_pending <= 1'b1;
        end else begin
            state <= next_state;
            por_pending <= 1'b0;
        end
    end

    // counter length for each phase
    always_comb begin
        len = `RSI_ACTIVE_CYCLES;
        load = 1'b0;
        next_state = state;
        unique case (state)
            rsi_pkg::RSI_IDLE: begin
                if (start_req) begin
                    next_state = rsi_pkg::RSI_ACTIVE;
                end
            end
            rsi_pkg::RSI_ACTIVE: begin
                // static reset: hold here while undervoltage; the pin term is masked here since we drive the pin
                if (!uv_active && !src.ext_pin && !cnt_busy && !por_pending) begin
                    next_state = rsi_pkg::RSI_DELAY;
                    load = 1'b1;
                    len = crystal ? `RSI_DELAY_LONG : `RSI_DELAY_SHORT;
                end
            end
            rsi_pkg::RSI_DELAY: begin
                if (uv_active || src.ext_pin) begin
                    next_state = rsi_pkg::RSI_ACTIVE;
                end else if (cnt_done) begin
                    if (opt_q.pll_enable) begin
                        next_state = rsi_pkg::RSI_PLL_WAIT;
                        load = 1'b1;
                        len = PLL_LEN;
                    end else begin
                        next_state = rsi_pkg::RSI_FETCH;
                    end
                end
            end
            rsi_pkg::RSI_PLL_WAIT: begin
                if (cnt_done) begin
                    next_state = rsi_pkg::RSI_FETCH;
                end
            end
            rsi_pkg::RSI_FETCH: begin
                if (fetch_cnt == `RSI_FETCH_CYCLES) begin
                    next_state = rsi_pkg::RSI_IDLE;
                end
            end
            default: begin
                next_state = rsi_pkg::RSI_ACTIVE;
            end
        endcase
        // active phase minimum: watchdog pulse sets its own width
        if ((state == rsi_pkg::RSI_IDLE && start_req) || por_pending) begin
            load = 1'b1;
            len = src.watchdog ? WDG_LEN : `RSI_ACTIVE_CYCLES;
        end
    end

    rsi_counter #(.WIDTH(13)) u_phase_cnt (
        .clk(clk),
        .rstn(rstn),
        .load(load),
        .length(len),
        .busy(cnt_busy),
        .done(cnt_done)
    );

    // fetch phase cycle count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_cnt <= '0;
        end else if (state == rsi_pkg::RSI_FETCH) begin
            fetch_cnt <= fetch_cnt + 2'h1;
        end else if (next_state == rsi_pkg::RSI_FETCH) begin
            fetch_cnt <= 2'h1;
        end else begin
            fetch_cnt <= '0;
        end
    end

    // ==========================================================
    // pin and cpu outputs
    // pin is pulled low through active and delay; never driven high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reset_pin_oe <= 1'b1;
            reset_pin_out <= 1'b0;
        end else begin
            reset_pin_oe <= (next_state == rsi_pkg::RSI_ACTIVE) || (next_state == rsi_pkg::RSI_DELAY);
            reset_pin_out <= 1'b0;
        end
    end

    // cpu held until the fetch phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpu_reset <= 1'b1;
            cpu_clock_enable <= 1'b1;
            vector_fetch <= 1'b0;
            reset_vector <= `RSI_VECTOR_ADDR;
            oscillator_keep_running <= 1'b0;
        end else begin
            cpu_reset <= (next_state != rsi_pkg::RSI_IDLE) && (next_state != rsi_pkg::RSI_FETCH);
            cpu_clock_enable <= (next_state != rsi_pkg::RSI_PLL_WAIT);
            vector_fetch <= (next_state == rsi_pkg::RSI_FETCH);
            reset_vector <= `RSI_VECTOR_ADDR;
            oscillator_keep_running <= crystal;
        end
    end

    // ==========================================================
    // auxiliary detector and interrupt
    assign aux_raw = auxiliary_voltage_detector && opt_q.lvd_enable && !halt_mode;

    // live flag; frozen in halt
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aux_flag <= 1'b0;
            aux_flag_q <= 1'b0;
        end else if (!halt_mode) begin
            aux_flag <= aux_raw;
            aux_flag_q <= aux_flag;
        end
    end

    // pending event: set on rising flag, cleared once the irq is raised
    // or when the enable or the detector is off; set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aux_pending <= 1'b0;
        end else if (aux_flag && !aux_flag_q && !halt_mode) begin
            aux_pending <= 1'b1;
        end else if (!aux_voltage_irq_enable || !opt_q.lvd_enable || aux_voltage_irq) begin
            aux_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            aux_voltage_irq <= 1'b0;
            wake_from_wait <= 1'b0;
        end else begin
            aux_voltage_irq <= aux_pending && aux_voltage_irq_enable && !cpu_interrupt_mask && !halt_mode;
            wake_from_wait <= wait_mode && aux_pending && aux_voltage_irq_enable;
        end
    end

    // ==========================================================
    // register file
    assign integ_read = reg_read && (reg_addr == `RSI_OFS_INTEGRITY);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rc_trim_upper <= `RSI_TRIM_UPPER_RST;
            rc_trim_lower <= `RSI_TRIM_LOWER_RST;
            aux_voltage_irq_enable <= 1'b0;
        end else if (reg_write && !halt_mode) begin
            if (reg_addr == `RSI_OFS_TRIM_UPPER) begin
                rc_trim_upper <= reg_wdata;
            end
            if (reg_addr == `RSI_OFS_INTEGRITY) begin
                rc_trim_lower <= reg_wdata[`RSI_BIT_TRIM_HI:`RSI_BIT_TRIM_LO];
                aux_voltage_irq_enable <= reg_wdata[`RSI_BIT_AUX_IE];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rc_trim <= {`RSI_TRIM_UPPER_RST, `RSI_TRIM_LOWER_RST};
        end else begin
            rc_trim <= {rc_trim_upper, rc_trim_lower};
        end
    end

    // reset cause flags; set beats the read clear. these survive rstn
    // only in silicon; here rstn is the power-on reset.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            watchdog_reset_flag <= 1'b0;
            undervoltage_reset_flag <= 1'b0;
            last_source <= '0;
        end else begin
            if (uv_active) begin
                undervoltage_reset_flag <= 1'b1;
                watchdog_reset_flag <= 1'b0;
            end else if (src.watchdog) begin
                watchdog_reset_flag <= 1'b1;
                if (integ_read) begin
                    undervoltage_reset_flag <= 1'b0;
                end
            end else if (integ_read && !halt_mode) begin
                watchdog_reset_flag <= 1'b0;
                undervoltage_reset_flag <= 1'b0;
            end
            if (state == rsi_pkg::RSI_IDLE && start_req) begin
                last_source <= src;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            locked <= 1'b0;
        end else if (!halt_mode) begin
            locked <= pll_at_frequency && opt_q.pll_enable;
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                `RSI_OFS_TRIM_UPPER: reg_rdata <= rc_trim_upper;
                `RSI_OFS_INTEGRITY: reg_rdata <= {1'b0, rc_trim_lower, watchdog_reset_flag, locked,
                    undervoltage_reset_flag, aux_flag, aux_voltage_irq_enable};
                `RSI_OFS_SOURCE: reg_rdata <= {4'h0, last_source};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule // rsi_reset_integrity
`default_nettype wire

// ===== bench/rsi_reset_integrity_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// sequencing and interrupt checks at the ports
module rsi_reset_integrity_props (
    input wire logic clk,
    input wire logic rstn,
    input wire rsi_pkg::rsi_option_type option,
    input wire logic low_voltage_detector,
    input wire logic cpu_interrupt_mask,
    input wire logic halt_mode,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    input wire logic cpu_reset,
    input wire logic cpu_clock_enable,
    input wire logic vector_fetch,
    input wire logic [15:0] reset_vector,
    input wire logic aux_voltage_irq,
    input wire logic oscillator_keep_running
);
    logic [12:0] oe_cnt;
    logic xtal;
    // resonator codes sit above the rc code in the enum
    assign xtal = option.clk_src >= rsi_pkg::RSI_CLK_XTAL0;
    // length of the current pin-low stretch; 13 bits cover the long delay
    always_ff @(posedge clk) begin
        if (!rstn || !reset_pin_oe) begin
            oe_cnt <= 13'h0000;
        end else begin
            oe_cnt <= oe_cnt + 13'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_VECTOR_ADDR: assert property (vector_fetch |-> reset_vector == 16'hFFFE)
        else $error("reset vector address wrong during fetch");
    AST_FETCH_TWO: assert property ($rose(vector_fetch) |=> vector_fetch ##1 !vector_fetch)
        else $error("vector fetch not two cycles");
    AST_PIN_LOW_LEVEL: assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin driven high");
    AST_PIN_THROUGH_DELAY: assert property (cpu_reset && cpu_clock_enable |-> reset_pin_oe)
        else $error("pin released before delay ended");
    AST_DELAY_LENGTH: assert property ($fell(reset_pin_oe) |-> oe_cnt >= (xtal ? 13'h1010 : 13'h0110))
        else $error("pin low stretch too short");
    AST_FETCH_FOLLOWS: assert property ($fell(cpu_reset) |-> ##[0:1] vector_fetch)
        else $error("fetch does not follow the delay");
    AST_CLK_HELD_PLL: assert property (!cpu_clock_enable |-> option.pll_enable && cpu_reset)
        else $error("clock withheld without pll startup");
    AST_OSC_KEEP: assert property (option == $past(option, 4) && !cpu_reset |-> oscillator_keep_running == xtal)
        else $error("oscillator keep running wrong");
    AST_IRQ_GATED: assert property (aux_voltage_irq |-> !$past(cpu_interrupt_mask) && !$past(halt_mode))
        else $error("aux irq while masked or halted");
    AST_UV_STATIC: assert property ((option.lvd_enable && low_voltage_detector) [*8] |-> reset_pin_oe && cpu_reset)
        else $error("undervoltage not holding reset");
endmodule // rsi_reset_integrity_props

bind rsi_reset_integrity rsi_reset_integrity_props chk_u (
    .clk(clk), .rstn(rstn), .option(option), .low_voltage_detector(low_voltage_detector),
    .cpu_interrupt_mask(cpu_interrupt_mask), .halt_mode(halt_mode), .reset_pin_oe(reset_pin_oe),
    .reset_pin_out(reset_pin_out), .cpu_reset(cpu_reset), .cpu_clock_enable(cpu_clock_enable),
    .vector_fetch(vector_fetch), .reset_vector(reset_vector), .aux_voltage_irq(aux_voltage_irq),
    .oscillator_keep_running(oscillator_keep_running)
);
`default_nettype wire

// ===== bench/rsi_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external reset circuitry on the open-drain pin
module rsi_far_model (
    input wire logic pull_low,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    output logic reset_pin_in
);
    // weak pull-up: the pin is high unless either side sinks it
    assign reset_pin_in = !(pull_low || (reset_pin_oe && !reset_pin_out));
endmodule // rsi_far_model
`default_nettype wire

// ===== bench/rsi_reset_integrity_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
module rsi_reset_integrity_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    rsi_pkg::rsi_option_type option = '{rsi_pkg::RSI_CLK_RC, 1'b0, 1'b1};
    logic pull_low = 1'b0, uv = 1'b0, aux = 1'b0, wdg = 1'b0, ill = 1'b0;
    logic pll_ok = 1'b0, mask = 1'b1, wait_m = 1'b0, halt_m = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, r;
    logic pin_in, pin_out, pin_oe, cpu_rst, clk_en, fetch, irq, wake, osc_keep, pll_seen, si, sw;
    logic [15:0] vec;
    logic [9:0] trim;
    int num_errors = 0;
    int checked = 0;
    int oe_cycles;
    always #10 clk = ~clk;
    rsi_far_model far_u (.pull_low(pull_low), .reset_pin_oe(pin_oe), .reset_pin_out(pin_out), .reset_pin_in(pin_in));
    rsi_reset_integrity dut_u (
        .clk(clk), .rstn(rstn), .option(option), .reset_pin_in(pin_in), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .low_voltage_detector(uv), .auxiliary_voltage_detector(aux),
        .watchdog_underflow(wdg), .illegal_opcode(ill), .pll_at_frequency(pll_ok), .cpu_interrupt_mask(mask),
        .wait_mode(wait_m), .halt_mode(halt_m), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
        .reg_read(rd), .reg_rdata(rdata), .cpu_reset(cpu_rst), .cpu_clock_enable(clk_en), .vector_fetch(fetch),
        .reset_vector(vec), .aux_voltage_irq(irq), .wake_from_wait(wake), .oscillator_keep_running(osc_keep),
        .rc_trim(trim)
    );
    // ==========================================
    // tasks
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // waits for the vector fetch, counting pin-low cycles on the way
    task automatic run_reset(input int lo, input int hi);
        oe_cycles = 0;
        pll_seen = 1'b0;
        for (int i = 0; i < 6000 && fetch !== 1'b1; i++) begin
            @(negedge clk);
            oe_cycles += (pin_oe === 1'b1);
            pll_seen |= (clk_en === 1'b0);
        end
        if (fetch !== 1'b1) begin
            num_errors++;
            $display("Error fetch expected 1 seen 0");
            close_out();
        end
        `CHK("pin low cycles", 1'b1, oe_cycles >= lo && oe_cycles <= hi)
        `CHK("vector", 16'hFFFE, vec)
        @(negedge clk);
        `CHK("fetch second cycle", 1'b1, fetch)
        @(negedge clk);
        `CHK("fetch over", 1'b0, fetch)
    endtask
    // short observation window for the interrupt and wake outputs
    task automatic watch_irq();
        si = 1'b0;
        sw = 1'b0;
        repeat (12) begin
            @(negedge clk);
            si |= (irq === 1'b1);
            sw |= (wake === 1'b1);
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK("pin oe in reset", 1'b1, pin_oe)
        @(posedge clk);
        rstn <= 1'b1;
        run_reset(272, 4095);
        reg_rd(2'h0, r);
        `CHK("trim upper", 8'h80, r)
        reg_rd(2'h1, r);
        `CHK("integrity", 8'h60, r & 8'hFB)
        `CHK("trim", 10'h203, trim)
        pll_ok <= 1'b1;
        reg_wr(2'h0, 8'h5A);
        reg_wr(2'h1, 8'h23);
        reg_rd(2'h1, r);
        `CHK("integrity written", 8'h21, r & 8'hFB)
        `CHK("trim written", 10'h169, trim)
        reg_rd(2'h3, r);
        `CHK("unmapped", 8'h00, r)
        $display("test registers done");
        @(posedge clk);
        aux <= 1'b1;
        wait_m <= 1'b1;
        watch_irq();
        `CHK("irq masked", 1'b0, si)
        reg_rd(2'h1, r);
        `CHK("aux flag", 8'h02, r & 8'h02)
        @(posedge clk);
        mask <= 1'b0;
        watch_irq();
        `CHK("irq", 1'b1, si)
        `CHK("wake", 1'b1, sw)
        @(posedge clk);
        aux <= 1'b0;
        option.lvd_enable <= 1'b0;
        repeat (4) @(posedge clk);
        aux <= 1'b1;
        watch_irq();
        `CHK("irq detector off", 1'b0, si)
        @(posedge clk);
        aux <= 1'b0;
        option.lvd_enable <= 1'b1;
        halt_m <= 1'b1;
        repeat (4) @(posedge clk);
        aux <= 1'b1;
        watch_irq();
        `CHK("irq in halt", 1'b0, si)
        reg_wr(2'h0, 8'h11);
        reg_rd(2'h0, r);
        `CHK("trim frozen in halt", 8'h5A, r)
        @(posedge clk);
        halt_m <= 1'b0;
        mask <= 1'b1;
        aux <= 1'b0;
        wait_m <= 1'b0;
        $display("test aux detector done");
        // watchdog, illegal opcode, pin during halt, undervoltage in turn
        @(posedge clk);
        wdg <= 1'b1;
        @(posedge clk);
        wdg <= 1'b0;
        run_reset(272, 4095);
        reg_rd(2'h2, r);
        `CHK("source watchdog", 8'h02, r)
        reg_rd(2'h1, r);
        `CHK("watchdog flag", 8'h10, r & 8'h10)
        reg_rd(2'h1, r);
        `CHK("watchdog flag read clear", 8'h00, r & 8'h10)
        @(posedge clk);
        ill <= 1'b1;
        @(posedge clk);
        ill <= 1'b0;
        run_reset(272, 4095);
        reg_rd(2'h2, r);
        `CHK("source illegal", 8'h01, r)
        @(posedge clk);
        halt_m <= 1'b1;
        pull_low <= 1'b1;
        repeat (20) @(posedge clk);
        pull_low <= 1'b0;
        halt_m <= 1'b0;
        run_reset(256, 4095);
        reg_rd(2'h2, r);
        `CHK("source pin", 8'h08, r)
        @(posedge clk);
        uv <= 1'b1;
        repeat (40) @(posedge clk);
        @(negedge clk);
        `CHK("pin low in undervoltage", 1'b0, pin_in)
        @(posedge clk);
        uv <= 1'b0;
        run_reset(256, 4095);
        reg_rd(2'h2, r);
        `CHK("source undervoltage", 8'h04, r)
        reg_rd(2'h1, r);
        `CHK("undervoltage flags", 8'h04, r & 8'h14)
        $display("test reset sources done");
        @(posedge clk);
        option.clk_src <= rsi_pkg::RSI_CLK_XTAL2;
        option.pll_enable <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("resonator kept running", 1'b1, osc_keep)
        @(posedge clk);
        ill <= 1'b1;
        @(posedge clk);
        ill <= 1'b0;
        run_reset(4112, 4400);
        `CHK("clock withheld for pll", 1'b1, pll_seen)
        reg_rd(2'h1, r);
        `CHK("pll locked", 8'h08, r & 8'h08)
        $display("test resonator delay done");
        close_out();
    end
endmodule // rsi_reset_integrity_tb_top
`default_nettype wire
